// ---- design/gcim_ctrl.sv ----
// Operation
// - Control bit 7 rising edge returns the whole device to default configuration.
// - Suspend bit 6 set floats the interrupt output and ignores all events.
// - Any toggle of acknowledge bit 5 clears pending interrupts, output high, unless an unmasked event arrives in that same cycle.
// - Counter clear bit 4 set clears and holds all status counters at zero.
// - Sample bit 3 set lets error counters update only on one-second ticks.
// - Pause bit 2 high stops line code violation counting while out of frame.
// - Pause bit 2 low keeps line code violation counting while out of frame.
// - Double-speed bit 0 doubles HDLC clock; access gap 160ns becomes 80ns.
// - Each mask bit enables its interrupt source when one, blocks when zero.
// - Mask bit 7: interrupt on each change of basic frame sync loss.
// - Mask bit 6: interrupt on each change of signaling multiframe sync.
// - Mask bit 5: interrupt on each change of CRC-4 multiframe sync.
// - Mask bit 4: interrupt on each change of received alarm indication.
// - Mask bit 3: interrupt on each change of loss-of-signal state.
// - Mask bit 2: interrupt on two consecutive errored frame alignment signals.
// - Mask bit 1: interrupt on each change of remote multiframe alarm.
// - Mask bit 0: interrupt on each controlled frame slip.
`default_nettype none
module gcim_ctrl
  import gcim_pkg::*;
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // microprocessor register port
  input  wire logic              reg_cs,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  input  wire logic [4:0]        reg_addr,
  input  wire logic [7:0]        reg_wdata,
  output var  logic [7:0]        reg_rdata,
  // event sources
  input  wire gcim_level_type    ev_level,
  input  wire gcim_pulse_type    ev_pulse,
  input  wire logic              out_of_frame,
  input  wire logic              one_sec_tick,
  // interrupt request pin
  output var  logic              irq_n_o,
  output var  logic              irq_oe_n,
  // device control
  output var  logic              soft_reset,
  output var  gcim_cnt_ctrl_type cnt_ctrl,
  output var  logic              hdlc_double_speed,
  output var  logic [7:0]        hdlc_gap_cycles
);

  gcim_state_type s_q;
  gcim_state_type s_d;

  logic [7:0] lvl_vec;
  logic [7:0] prev_vec;
  logic [7:0] evt_vec;
  logic       wr_ctrl;
  logic       wr_mask;
  logic       rd_hit;

  // ----------------------------------------
  // event vector
  // ----------------------------------------
  function automatic logic [7:0] gcim_lvl_vec(input gcim_level_type l);
    gcim_lvl_vec = {l.frame_sync_lost, l.sig_mf_sync, l.crc_mf_sync, l.ais,
                    l.los, 1'b0, l.remote_mf_alarm, 1'b0};
  endfunction

  always_comb begin
    lvl_vec  = gcim_lvl_vec(ev_level);
    prev_vec = gcim_lvl_vec(s_q.prev);
    evt_vec  = ((lvl_vec ^ prev_vec) & GCIM_LEVEL_EVENTS)
             | {5'h00, ev_pulse.cons_fas_err, 1'b0, ev_pulse.frame_slip};
    wr_ctrl  = reg_cs && reg_wr && (reg_addr == GCIM_CTRL_OFS);
    wr_mask  = reg_cs && reg_wr && (reg_addr == GCIM_MASK_OFS);
    rd_hit   = reg_cs && reg_rd;
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    logic [7:0] ctrl_n;
    logic [7:0] pend_n;
    logic       ack;
    logic       susp;
    ctrl_n = s_q.ctrl;
    pend_n = s_q.pend;
    ack    = 1'b0;
    susp   = 1'b0;
    s_d    = s_q;

    s_d.prev       = ev_level;
    s_d.soft_reset = 1'b0;

    if (wr_ctrl) begin
      ctrl_n = reg_wdata;
      ack    = reg_wdata[GCIM_B_ACK] ^ s_q.ctrl[GCIM_B_ACK];
    end
    if (wr_mask) begin
      s_d.mask = reg_wdata;
    end

    susp = ctrl_n[GCIM_B_SUSPEND];
    if (ack) begin
      pend_n = 8'h00;
    end
    if (!susp) begin
      pend_n = pend_n | (evt_vec & s_q.mask);
    end
    s_d.ctrl = ctrl_n;
    s_d.pend = pend_n;

    s_d.irq_n    = ~|(pend_n & s_q.mask) | susp;
    s_d.irq_oe_n = susp;

    s_d.cnt.clear      = ctrl_n[GCIM_B_CNT_CLEAR];
    s_d.cnt.update     = !ctrl_n[GCIM_B_SAMPLE] || one_sec_tick;
    s_d.cnt.lcv_enable = !(ctrl_n[GCIM_B_OOF_PAUSE] && out_of_frame);
    s_d.hdlc_double    = ctrl_n[GCIM_B_DOUBLE];
    s_d.hdlc_gap       = ctrl_n[GCIM_B_DOUBLE] ? GCIM_HDLC_FAST_CYC : GCIM_HDLC_GAP_CYC;

    if (rd_hit) begin
      unique case (reg_addr)
        GCIM_CTRL_OFS: s_d.rdata = s_q.ctrl;
        GCIM_MASK_OFS: s_d.rdata = s_q.mask;
        GCIM_PEND_OFS: s_d.rdata = s_q.pend;
        default:       s_d.rdata = 8'h00;
      endcase
    end

    if (wr_ctrl && reg_wdata[GCIM_B_SOFT_RESET] && !s_q.ctrl[GCIM_B_SOFT_RESET]) begin
      s_d.ctrl           = GCIM_CTRL_RST;
      s_d.mask           = GCIM_MASK_RST;
      s_d.pend           = 8'h00;
      s_d.irq_n          = 1'b1;
      s_d.irq_oe_n       = 1'b0;
      s_d.cnt.clear      = 1'b0;
      s_d.cnt.update     = 1'b1;
      s_d.cnt.lcv_enable = 1'b1;
      s_d.hdlc_double    = 1'b0;
      s_d.hdlc_gap       = GCIM_HDLC_GAP_CYC;
      s_d.soft_reset     = 1'b1;
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q.ctrl           <= GCIM_CTRL_RST;
      s_q.mask           <= GCIM_MASK_RST;
      s_q.pend           <= 8'h00;
      s_q.prev           <= '0;
      s_q.soft_reset     <= 1'b0;
      s_q.rdata          <= 8'h00;
      s_q.irq_n          <= 1'b1;
      s_q.irq_oe_n       <= 1'b0;
      s_q.cnt.clear      <= 1'b0;
      s_q.cnt.update     <= 1'b1;
      s_q.cnt.lcv_enable <= 1'b1;
      s_q.hdlc_double    <= 1'b0;
      s_q.hdlc_gap       <= GCIM_HDLC_GAP_CYC;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign reg_rdata         = s_q.rdata;
  assign irq_n_o           = s_q.irq_n;
  assign irq_oe_n          = s_q.irq_oe_n;
  assign soft_reset        = s_q.soft_reset;
  assign cnt_ctrl          = s_q.cnt;
  assign hdlc_double_speed = s_q.hdlc_double;
  assign hdlc_gap_cycles   = s_q.hdlc_gap;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_SOFT_RESET: assert property (
    wr_ctrl && reg_wdata[GCIM_B_SOFT_RESET] && !s_q.ctrl[GCIM_B_SOFT_RESET]
    |=> soft_reset && s_q.ctrl == GCIM_CTRL_RST && s_q.mask == GCIM_MASK_RST && irq_n_o)
    else $error("soft reset did not restore defaults");

  AST_SUSPEND_FLOAT: assert property (
    s_q.ctrl[GCIM_B_SUSPEND] && !soft_reset |-> irq_oe_n && $stable(s_q.pend) || $fell(s_q.pend != 0))
    else $error("suspended interrupt pin driven or event latched");

  AST_ACK_CLEAR: assert property (
    wr_ctrl && (reg_wdata[GCIM_B_ACK] != s_q.ctrl[GCIM_B_ACK]) && evt_vec == 8'h00
    |=> s_q.pend == 8'h00 && irq_n_o)
    else $error("acknowledge did not clear pending");

  AST_CNT_CLEAR: assert property (
    s_q.ctrl[GCIM_B_CNT_CLEAR] && !soft_reset |-> cnt_ctrl.clear)
    else $error("counter clear not driven");

  AST_SAMPLE_GATE: assert property (
    s_q.ctrl[GCIM_B_SAMPLE] && !one_sec_tick && !wr_ctrl |=> !cnt_ctrl.update)
    else $error("counters updated outside one-second tick");

  AST_LCV_PAUSE: assert property (
    !wr_ctrl |=> cnt_ctrl.lcv_enable == !($past(s_q.ctrl[GCIM_B_OOF_PAUSE]) && $past(out_of_frame)))
    else $error("line code violation enable wrong");

  AST_HDLC_GAP: assert property (
    hdlc_gap_cycles == (hdlc_double_speed ? GCIM_HDLC_FAST_CYC : GCIM_HDLC_GAP_CYC))
    else $error("hdlc gap mismatch");

  AST_MASK_BLOCK: assert property (
    !wr_ctrl && !wr_mask |=> (s_q.pend & ~$past(s_q.pend) & ~s_q.mask) == 8'h00)
    else $error("masked event latched");

  AST_CHANGE_LATCH: assert property (
    (evt_vec & s_q.mask) != 8'h00 && !s_q.ctrl[GCIM_B_SUSPEND] && !wr_ctrl
    |=> !irq_n_o [*2] or (!irq_n_o ##1 s_q.pend == 8'h00)
        or (!irq_n_o ##1 s_q.ctrl[GCIM_B_SUSPEND]))
    else $error("unmasked event did not raise interrupt");

  AST_IRQ_LATCHED: assert property (
    !irq_n_o && !wr_ctrl && !$past(wr_mask) |=> !irq_n_o)
    else $error("interrupt released without acknowledge");

  AST_FRAME_SYNC_EVT: assert property (
    s_q.mask[GCIM_E_FRAME_SYNC] && !s_q.ctrl[GCIM_B_SUSPEND] && !wr_ctrl
    && ev_level.frame_sync_lost != s_q.prev.frame_sync_lost |=> s_q.pend[GCIM_E_FRAME_SYNC])
    else $error("frame sync change not latched");

  AST_SIG_MF_EVT: assert property (
    s_q.mask[GCIM_E_SIG_MF] && !s_q.ctrl[GCIM_B_SUSPEND] && !wr_ctrl
    && ev_level.sig_mf_sync != s_q.prev.sig_mf_sync |=> s_q.pend[GCIM_E_SIG_MF])
    else $error("signaling multiframe change not latched");

  AST_CRC_MF_EVT: assert property (
    s_q.mask[GCIM_E_CRC_MF] && !s_q.ctrl[GCIM_B_SUSPEND] && !wr_ctrl
    && ev_level.crc_mf_sync != s_q.prev.crc_mf_sync |=> s_q.pend[GCIM_E_CRC_MF])
    else $error("crc multiframe change not latched");

  AST_AIS_EVT: assert property (
    s_q.mask[GCIM_E_AIS] && !s_q.ctrl[GCIM_B_SUSPEND] && !wr_ctrl
    && ev_level.ais != s_q.prev.ais |=> s_q.pend[GCIM_E_AIS])
    else $error("alarm indication change not latched");

  AST_LOS_EVT: assert property (
    s_q.mask[GCIM_E_LOS] && !s_q.ctrl[GCIM_B_SUSPEND] && !wr_ctrl
    && ev_level.los != s_q.prev.los |=> s_q.pend[GCIM_E_LOS])
    else $error("loss of signal change not latched");

  AST_CONS_FAS_EVT: assert property (
    s_q.mask[GCIM_E_CONS_FAS] && !s_q.ctrl[GCIM_B_SUSPEND] && !wr_ctrl
    && ev_pulse.cons_fas_err |=> s_q.pend[GCIM_E_CONS_FAS])
    else $error("errored alignment pair not latched");

  AST_REMOTE_MF_EVT: assert property (
    s_q.mask[GCIM_E_REMOTE_MF] && !s_q.ctrl[GCIM_B_SUSPEND] && !wr_ctrl
    && ev_level.remote_mf_alarm != s_q.prev.remote_mf_alarm |=> s_q.pend[GCIM_E_REMOTE_MF])
    else $error("remote multiframe alarm change not latched");

  AST_SLIP_EVT: assert property (
    s_q.mask[GCIM_E_SLIP] && !s_q.ctrl[GCIM_B_SUSPEND] && !wr_ctrl
    && ev_pulse.frame_slip |=> s_q.pend[GCIM_E_SLIP])
    else $error("frame slip not latched");

  AST_SUSPEND_HIGH: assert property (
    s_q.ctrl[GCIM_B_SUSPEND] |-> irq_n_o && irq_oe_n)
    else $error("suspended interrupt pin not floated");

  AST_SUSPEND_DROP: assert property (
    s_q.ctrl[GCIM_B_SUSPEND] && !wr_ctrl |=> (s_q.pend & ~$past(s_q.pend)) == 8'h00)
    else $error("event latched while suspended");

  AST_RUN_DRIVEN: assert property (
    !s_q.ctrl[GCIM_B_SUSPEND] |-> !irq_oe_n)
    else $error("interrupt pin floated while running");

  AST_ACK_SET_WINS: assert property (
    wr_ctrl && reg_wdata[GCIM_B_ACK] != s_q.ctrl[GCIM_B_ACK] && !reg_wdata[GCIM_B_SUSPEND]
    && !reg_wdata[GCIM_B_SOFT_RESET] && (evt_vec & s_q.mask) != 8'h00 |=> s_q.pend != 8'h00)
    else $error("event lost against acknowledge");

  AST_ACK_HOLD: assert property (
    wr_ctrl && reg_wdata[GCIM_B_ACK] == s_q.ctrl[GCIM_B_ACK] && !reg_wdata[GCIM_B_SOFT_RESET]
    && s_q.pend != 8'h00 |=> s_q.pend != 8'h00)
    else $error("pending cleared without acknowledge toggle");

  AST_CNT_RESUME: assert property (
    !s_q.ctrl[GCIM_B_CNT_CLEAR] |-> !cnt_ctrl.clear)
    else $error("counter clear held without control bit");

  AST_SAMPLE_FREE: assert property (
    !s_q.ctrl[GCIM_B_SAMPLE] |-> cnt_ctrl.update)
    else $error("counter update blocked without sample bit");

  AST_SAMPLE_TICK: assert property (
    s_q.ctrl[GCIM_B_SAMPLE] && one_sec_tick && !wr_ctrl |=> cnt_ctrl.update)
    else $error("counter update missing on one-second tick");

  AST_LCV_FREE: assert property (
    !s_q.ctrl[GCIM_B_OOF_PAUSE] && !wr_ctrl |=> cnt_ctrl.lcv_enable)
    else $error("line code violation counting stopped without pause");

  AST_HDLC_DOUBLE: assert property (
    hdlc_double_speed == s_q.ctrl[GCIM_B_DOUBLE])
    else $error("hdlc double speed does not follow control");

  AST_SOFT_PULSE: assert property (
    soft_reset && !wr_ctrl |=> !soft_reset)
    else $error("soft reset longer than one cycle");

  AST_SOFT_ONLY_RISE: assert property (
    !(wr_ctrl && reg_wdata[GCIM_B_SOFT_RESET] && !s_q.ctrl[GCIM_B_SOFT_RESET]) |=> !soft_reset)
    else $error("soft reset without rising control bit");

  AST_SOFT_CLEARS: assert property (
    soft_reset |-> s_q.pend == 8'h00 && irq_n_o && !cnt_ctrl.clear && cnt_ctrl.update && !hdlc_double_speed)
    else $error("soft reset left state behind");

  AST_MASK_STORE: assert property (
    wr_mask |=> s_q.mask == $past(reg_wdata))
    else $error("mask write not stored");

  AST_IRQ_NEEDS_PEND: assert property (
    !irq_n_o |-> s_q.pend != 8'h00)
    else $error("interrupt request without pending event");

  AST_IRQ_ASSERT: assert property (
    (s_q.pend & s_q.mask) != 8'h00 && !s_q.ctrl[GCIM_B_SUSPEND] && !wr_ctrl
    |=> !irq_n_o)
    else $error("pending unmasked event without interrupt request");

endmodule // gcim_ctrl
`default_nettype wire

// ---- design/gcim_pkg.sv ----
`default_nettype none
package gcim_pkg;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [4:0] GCIM_CTRL_OFS = 5'h1a;
  localparam logic [4:0] GCIM_MASK_OFS = 5'h1e;
  localparam logic [4:0] GCIM_PEND_OFS = 5'h1f;

  localparam logic [7:0] GCIM_CTRL_RST = 8'h00;
  localparam logic [7:0] GCIM_MASK_RST = 8'h00;

  // control word bit positions
  localparam int GCIM_B_SOFT_RESET = 7;
  localparam int GCIM_B_SUSPEND    = 6;
  localparam int GCIM_B_ACK        = 5;
  localparam int GCIM_B_CNT_CLEAR  = 4;
  localparam int GCIM_B_SAMPLE     = 3;
  localparam int GCIM_B_OOF_PAUSE  = 2;
  localparam int GCIM_B_RESERVED   = 1;
  localparam int GCIM_B_DOUBLE     = 0;

  // mask / pending bit positions
  localparam int GCIM_E_FRAME_SYNC = 7;
  localparam int GCIM_E_SIG_MF     = 6;
  localparam int GCIM_E_CRC_MF     = 5;
  localparam int GCIM_E_AIS        = 4;
  localparam int GCIM_E_LOS        = 3;
  localparam int GCIM_E_CONS_FAS   = 2;
  localparam int GCIM_E_REMOTE_MF  = 1;
  localparam int GCIM_E_SLIP       = 0;

  // events taken from level changes; the rest are pulses
  localparam logic [7:0] GCIM_LEVEL_EVENTS = 8'hfa;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int GCIM_CLK_PERIOD_NS  = 8;
  localparam int GCIM_HDLC_GAP_NS    = 160;
  localparam int GCIM_HDLC_FAST_NS   = 80;
  localparam logic [7:0] GCIM_HDLC_GAP_CYC  =
    8'((GCIM_HDLC_GAP_NS + GCIM_CLK_PERIOD_NS - 1) / GCIM_CLK_PERIOD_NS);
  localparam logic [7:0] GCIM_HDLC_FAST_CYC =
    8'((GCIM_HDLC_FAST_NS + GCIM_CLK_PERIOD_NS - 1) / GCIM_CLK_PERIOD_NS);

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic frame_sync_lost;
    logic sig_mf_sync;
    logic crc_mf_sync;
    logic ais;
    logic los;
    logic remote_mf_alarm;
  } gcim_level_type;

  typedef struct packed {
    logic cons_fas_err;
    logic frame_slip;
  } gcim_pulse_type;

  typedef struct packed {
    logic clear;
    logic update;
    logic lcv_enable;
  } gcim_cnt_ctrl_type;

  typedef struct packed {
    logic [7:0]        ctrl;
    logic [7:0]        mask;
    logic [7:0]        pend;
    gcim_level_type    prev;
    logic              soft_reset;
    logic [7:0]        rdata;
    logic              irq_n;
    logic              irq_oe_n;
    gcim_cnt_ctrl_type cnt;
    logic              hdlc_double;
    logic [7:0]        hdlc_gap;
  } gcim_state_type;

endpackage : gcim_pkg
`default_nettype wire

// ---- verification/test_e1_global_control_and_irq_mask.sv ----
`default_nettype none
module test_e1_global_control_and_irq_mask;
  import gcim_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic              clk = 0;
  logic              rst_n = 0;
  logic              reg_cs = 0;
  logic              reg_wr = 0;
  logic              reg_rd = 0;
  logic [4:0]        reg_addr = 5'h00;
  logic [7:0]        reg_wdata = 8'h00;
  logic [7:0]        reg_rdata;
  logic [7:0]        ev8 = 8'h00;
  logic              oof = 0;
  logic              tick = 0;
  logic              irq_n;
  logic              irq_oe_n;
  logic              soft_reset;
  gcim_cnt_ctrl_type cnt;
  logic              dbl;
  logic [7:0]        gap;
  logic [7:0]        ctrl_sh = 8'h00;
  logic [7:0]        rv;
  int                error_cnt = 0;
  int                total_checks = 0;
  int                sr_cnt = 0;
  wire gcim_level_type lvl = {ev8[7], ev8[6], ev8[5], ev8[4], ev8[3], ev8[1]};
  wire gcim_pulse_type pls = {ev8[2], ev8[0]};

  always #4 clk = ~clk;
  always @(posedge clk) if (soft_reset === 1'b1) sr_cnt++;

  gcim_ctrl DUT (.clk(clk), .rst_n(rst_n), .reg_cs(reg_cs), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .ev_level(lvl),
    .ev_pulse(pls), .out_of_frame(oof), .one_sec_tick(tick), .irq_n_o(irq_n),
    .irq_oe_n(irq_oe_n), .soft_reset(soft_reset), .cnt_ctrl(cnt),
    .hdlc_double_speed(dbl), .hdlc_gap_cycles(gap));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task chk(input string n, input logic [7:0] s, input logic [7:0] e);
    total_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task cyc();
    @(posedge clk);
    #1;
  endtask
  task wr(input logic [4:0] a, input logic [7:0] d);
    cyc();
    reg_cs = 1;
    reg_wr = 1;
    reg_addr = a;
    reg_wdata = d;
    cyc();
    reg_cs = 0;
    reg_wr = 0;
    cyc();
  endtask
  task rd(input logic [4:0] a);
    cyc();
    reg_cs = 1;
    reg_rd = 1;
    reg_addr = a;
    cyc();
    reg_cs = 0;
    reg_rd = 0;
    cyc();
    rv = reg_rdata;
  endtask
  task ctl(input logic [7:0] d);
    ctrl_sh = d & 8'hfd;
    wr(GCIM_CTRL_OFS, ctrl_sh);
  endtask
  task fire(input int i);
    cyc();
    ev8 = 8'h01 << i;
    cyc();
    ev8 = 8'h00;
    cyc();
  endtask
  task test_done();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_reset();
    chk("irq", {7'h0, irq_n}, 8'h01);
    chk("oe", {7'h0, irq_oe_n}, 8'h00);
    chk("cnt", {5'h0, cnt}, 8'h03);
    chk("gap", gap, GCIM_HDLC_GAP_CYC);
    rd(GCIM_MASK_OFS);
    chk("mask", rv, 8'h00);
  endtask
  task t_events();
    fire(0);
    chk("masked", {7'h0, irq_n}, 8'h01);
    for (int i = 0; i < 8; i++) begin
      wr(GCIM_MASK_OFS, 8'h01 << i);
      fire(i);
      chk("irq", {7'h0, irq_n}, 8'h00);
      rd(GCIM_PEND_OFS);
      chk("pend", rv, 8'h01 << i);
      ctl(ctrl_sh ^ 8'h20);
      chk("ack", {7'h0, irq_n}, 8'h01);
      rd(GCIM_PEND_OFS);
      chk("pend0", rv, 8'h00);
    end
    wr(GCIM_PEND_OFS, 8'hff);
    rd(GCIM_PEND_OFS);
    chk("pend_ro", rv, 8'h00);
    rd(5'h05);
    chk("unmapped", rv, 8'h00);
  endtask
  task t_suspend();
    wr(GCIM_MASK_OFS, 8'h01);
    ctl(ctrl_sh | 8'h40);
    chk("oe_susp", {7'h0, irq_oe_n}, 8'h01);
    fire(0);
    chk("irq_float", {7'h0, irq_n}, 8'h01);
    ctl(ctrl_sh & 8'hbf);
    chk("oe_run", {7'h0, irq_oe_n}, 8'h00);
    chk("irq_susp", {7'h0, irq_n}, 8'h01);
    rd(GCIM_PEND_OFS);
    chk("pend_susp", rv, 8'h00);
  endtask
  task t_counters();
    ctl(8'h10);
    chk("clear", {7'h0, cnt.clear}, 8'h01);
    ctl(8'h08);
    chk("clear_off", {7'h0, cnt.clear}, 8'h00);
    chk("upd_hold", {7'h0, cnt.update}, 8'h00);
    tick = 1;
    cyc();
    tick = 0;
    chk("upd_tick", {7'h0, cnt.update}, 8'h01);
    cyc();
    chk("upd_once", {7'h0, cnt.update}, 8'h00);
    ctl(8'h04);
    oof = 1;
    cyc();
    cyc();
    chk("lcv_pause", {7'h0, cnt.lcv_enable}, 8'h00);
    ctl(8'h00);
    chk("lcv_run", {7'h0, cnt.lcv_enable}, 8'h01);
    oof = 0;
    ctl(8'h01);
    chk("dbl", {7'h0, dbl}, 8'h01);
    chk("gap_fast", gap, GCIM_HDLC_FAST_CYC);
    rd(GCIM_CTRL_OFS);
    chk("ctrl_rb", rv, 8'h01);
    ctl(8'h00);
    chk("gap_norm", gap, GCIM_HDLC_GAP_CYC);
  endtask
  task t_soft();
    wr(GCIM_MASK_OFS, 8'hff);
    fire(0);
    chk("irq_pre_soft", {7'h0, irq_n}, 8'h00);
    ctl(8'h80);
    chk("irq_soft", {7'h0, irq_n}, 8'h01);
    cyc();
    chk("soft_pulse", sr_cnt[7:0], 8'h01);
    rd(GCIM_MASK_OFS);
    chk("mask_dflt", rv, GCIM_MASK_RST);
    rd(GCIM_CTRL_OFS);
    chk("ctrl_dflt", rv, GCIM_CTRL_RST);
    rd(GCIM_PEND_OFS);
    chk("pend_dflt", rv, 8'h00);
  endtask
  task t_hw_reset();
    wr(GCIM_MASK_OFS, 8'h01);
    fire(0);
    chk("irq_pre_rst", {7'h0, irq_n}, 8'h00);
    rst_n = 0;
    cyc();
    cyc();
    rst_n = 1;
    ctrl_sh = 8'h00;
    chk("irq_rst", {7'h0, irq_n}, 8'h01);
    chk("oe_rst", {7'h0, irq_oe_n}, 8'h00);
    rd(GCIM_MASK_OFS);
    chk("mask_rst", rv, GCIM_MASK_RST);
  endtask

  initial begin
    repeat (20) @(posedge clk);
    #1;
    rst_n = 1;
    t_reset();
    t_events();
    t_suspend();
    t_counters();
    t_soft();
    t_hw_reset();
    test_done();
  end
  initial begin
    repeat (4000) @(posedge clk);
    error_cnt++;
    test_done();
  end
endmodule // test_e1_global_control_and_irq_mask
`default_nettype wire
